// ===== core/fpcsr_pkg.sv
// package of offsets, field layouts and reset values for the fp control/status bank
package fpcsr_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FPCSR_OFF_CPAC = 8'h00;
  localparam logic [7:0] FPCSR_OFF_CTXA = 8'h04;
  localparam logic [7:0] FPCSR_OFF_STAT = 8'h08;
  localparam logic [7:0] FPCSR_OFF_DFLT = 8'h0c;
  localparam logic [7:0] FPCSR_OFF_IRQS = 8'h10;
  localparam logic [7:0] FPCSR_OFF_IRQM = 8'h14;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FPCSR_CTXA_LSB = 3;
  localparam int FPCSR_NZCV_LSB = 28;
  localparam int FPCSR_AHP_BIT = 26;
  localparam int FPCSR_DN_BIT = 25;
  localparam int FPCSR_FZ_BIT = 24;
  localparam int FPCSR_RM_LSB = 22;
  localparam int FPCSR_IDC_BIT = 7;
  localparam int FPCSR_IXC_BIT = 4;
  localparam int FPCSR_CP10_LSB = 20;
  localparam int FPCSR_CP11_LSB = 22;
  // ----------------------------------------------------------------
  // masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] FPCSR_CTXA_MASK = 32'hffff_fff8;
  localparam logic [31:0] FPCSR_CTRL_MASK = 32'h07c0_0000;
  localparam logic [31:0] FPCSR_NZCV_MASK = 32'hf000_0000;
  localparam logic [31:0] FPCSR_EXC_MASK = 32'h0000_009f;
  localparam logic [31:0] FPCSR_IRQ_EXC_MASK = 32'h0000_008f;
  localparam logic [31:0] FPCSR_CPAC_MASK = 32'h00f0_0000;
  localparam logic [31:0] FPCSR_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] FPCSR_DFLT_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPCSR_RM_NEAREST = 2'h0,
    FPCSR_RM_PLUS_INF = 2'h1,
    FPCSR_RM_MINUS_INF = 2'h2,
    FPCSR_RM_ZERO = 2'h3
  } fpcsr_round_t;
  typedef enum logic [1:0] {
    FPCSR_CP_DENIED = 2'h0,
    FPCSR_CP_PRIV = 2'h1,
    FPCSR_CP_RSVD = 2'h2,
    FPCSR_CP_FULL = 2'h3
  } fpcsr_cpaccess_t;
  localparam logic [1:0] FPCSR_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] FPCSR_HSIZE_WORD = 3'h2;
endpackage

// ===== core/fpcsr_access_check.sv
// access decision for coprocessor access fields and privilege
`timescale 1ns/1ps
module fpcsr_access_check
  import fpcsr_pkg::*;
(
  input wire logic [1:0] cp_field, // access field of one coprocessor
  input wire logic privileged, // current access is privileged
  input wire logic fp_request, // fp instruction is issued
  output logic allow, // instruction may proceed
  output logic fault // no-coprocessor fault raised
);
  wire logic priv_ok = (cp_field == FPCSR_CP_PRIV) && privileged;
  wire logic full_ok = (cp_field == FPCSR_CP_FULL);
  // reserved encoding is treated like denied: the safe choice for an unpredictable code
  assign allow = fp_request && (priv_ok || full_ok);
  assign fault = fp_request && !(priv_ok || full_ok);
endmodule // fpcsr_access_check

// ===== core/fpcsr_sticky.sv
// sticky flag bank: hardware set wins over software clear
`timescale 1ns/1ps
module fpcsr_sticky #(
  parameter int WIDTH = 8
) (
  input wire logic hclk, // core clock
  input wire logic hresetn, // async reset, active low
  input wire logic [WIDTH-1:0] set, // event pulses
  input wire logic [WIDTH-1:0] clr, // clear pulses
  output logic [WIDTH-1:0] flags // sticky state
);
  logic [WIDTH-1:0] flags_q;
  wire logic [WIDTH-1:0] flags_d;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // an event in the cycle of a clear wins, so no event is ever lost
      assign flags_d[i] = set[i] || (flags_q[i] && !clr[i]);
    end
  endgenerate
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_q <= {WIDTH{1'b0}};
    else
      flags_q <= flags_d;
  end
  assign flags = flags_q;
endmodule // fpcsr_sticky

// ===== core/fpcsr_regs.sv
// fp context/status register bank with ahb-lite slave and fp unit side ports
`timescale 1ns/1ps
module fpcsr_regs
  import fpcsr_pkg::*;
(
  input wire logic hclk, // core clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [3:0] hprot, // protection, bit 1 privileged
  input wire logic hready, // bus ready in
  input wire logic [31:0] hwdata, // write data
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  input wire logic fp_issue, // fp instruction issued
  input wire logic fp_issue_priv, // issuing code is privileged
  input wire logic cmp_valid, // comparison result valid
  input wire logic [3:0] cmp_nzcv, // comparison flags
  input wire logic [7:0] exc_set, // exception events, layout of status low byte
  input wire logic ctx_new, // new fp context created
  input wire logic ctx_alloc, // stack frame fp area allocated
  input wire logic [31:0] ctx_addr, // address of allocated area
  output logic fp_enable, // fp unit enabled for issue
  output logic fp_allow, // current issue allowed
  output logic no_coprocessor_fault_fault, // no-coprocessor fault pulse
  output logic half_precision_alt_select, // alternative half precision
  output logic default_nan_enable, // default nan mode
  output logic flush_to_zero_enable, // flush to zero mode
  output logic [1:0] rounding_select, // rounding mode
  output logic fp_irq, // exception interrupt to controller
  output logic irq // masked sticky status interrupt
);
  // ----------------------------------------------------------------
  // bus address phase capture
  // ----------------------------------------------------------------
  logic wr_pend_q, wr_pend_d;
  logic rd_pend_q, rd_pend_d;
  logic priv_q, priv_d;
  logic [7:0] addr_q, addr_d;
  wire logic addr_ok = (htrans == FPCSR_HTRANS_NONSEQ) && (hsize == FPCSR_HSIZE_WORD);
  // only whole-word single transfers are decoded; anything else passes as idle
  wire logic take = hsel && hready && addr_ok;
  assign wr_pend_d = take && hwrite;
  assign rd_pend_d = take && !hwrite;
  assign priv_d = take ? hprot[1] : priv_q;
  assign addr_d = take ? haddr[7:0] : addr_q;
  // pending flags live for one cycle only; the attributes are held until
  // the next accepted address, so a stalled data phase still sees them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      priv_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      priv_q <= priv_d;
      addr_q <= addr_d;
    end
  end
  // ----------------------------------------------------------------
  // data phase decode
  // ----------------------------------------------------------------
  wire logic sel_cpac = (addr_q == FPCSR_OFF_CPAC);
  wire logic sel_ctxa = (addr_q == FPCSR_OFF_CTXA);
  wire logic sel_stat = (addr_q == FPCSR_OFF_STAT);
  wire logic sel_dflt = (addr_q == FPCSR_OFF_DFLT);
  wire logic sel_irqs = (addr_q == FPCSR_OFF_IRQS);
  wire logic sel_irqm = (addr_q == FPCSR_OFF_IRQM);
  // unprivileged access to the access control register is ignored and reads zero
  wire logic cpac_ok = sel_cpac && priv_q;
  wire logic wr_cpac = wr_pend_q && cpac_ok;
  wire logic wr_ctxa = wr_pend_q && sel_ctxa;
  wire logic wr_stat = wr_pend_q && sel_stat;
  wire logic wr_dflt = wr_pend_q && sel_dflt;
  wire logic wr_irqm = wr_pend_q && sel_irqm;
  wire logic rd_irqs = rd_pend_q && sel_irqs;
  // ----------------------------------------------------------------
  // access control and enable
  // ----------------------------------------------------------------
  logic [31:0] cpac_q, cpac_d;
  // write data masked to the two access fields, all else reads zero
  assign cpac_d = wr_cpac ? (hwdata & FPCSR_CPAC_MASK) : cpac_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cpac_q <= FPCSR_RST_ZERO;
    else
      cpac_q <= cpac_d;
  end
  wire logic [1:0] acc_allow_v;
  wire logic [1:0] acc_fault_v;
  wire logic [1:0] cp_on_v;
  // the fp register file answers to both fields, so an issue needs the grant of
  // both; programming them differently only ever narrows what is allowed
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_cp
      wire logic [1:0] cp_field = (g == 0) ? cpac_q[FPCSR_CP10_LSB +: 2] :
                                  cpac_q[FPCSR_CP11_LSB +: 2];
      // 01 and 11 both leave the unit on for at least privileged code
      assign cp_on_v[g] = (cp_field == FPCSR_CP_PRIV) ||
                          (cp_field == FPCSR_CP_FULL);
      fpcsr_access_check u_access (
        .cp_field(cp_field),
        .privileged(fp_issue_priv),
        .fp_request(fp_issue),
        .allow(acc_allow_v[g]),
        .fault(acc_fault_v[g])
      );
    end
  endgenerate
  wire logic acc_allow = &acc_allow_v;
  wire logic acc_fault = |acc_fault_v;
  // ----------------------------------------------------------------
  // context address
  // ----------------------------------------------------------------
  logic [31:0] ctxa_q, ctxa_d;
  // hardware allocation wins over a software write in the same cycle
  // the area is eight-byte aligned, so the low three bits never hold state
  assign ctxa_d = ctx_alloc ? (ctx_addr & FPCSR_CTXA_MASK) :
                  wr_ctxa ? (hwdata & FPCSR_CTXA_MASK) : ctxa_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctxa_q <= FPCSR_RST_ZERO;
    else
      ctxa_q <= ctxa_d;
  end
  // ----------------------------------------------------------------
  // default and status control
  // ----------------------------------------------------------------
  logic [31:0] dflt_q, dflt_d;
  // only the control fields are stored; every other bit reads zero
  assign dflt_d = wr_dflt ? (hwdata & FPCSR_CTRL_MASK) : dflt_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dflt_q <= FPCSR_DFLT_RST;
    else
      dflt_q <= dflt_d;
  end
  logic [31:0] ctrl_q, ctrl_d;
  // a new context takes the defaults; it has priority over a software write
  assign ctrl_d = ctx_new ? dflt_q :
                  wr_stat ? (hwdata & FPCSR_CTRL_MASK) : ctrl_q;
  logic [3:0] nzcv_q, nzcv_d;
  // a compare result beats a status write in the same cycle: it is the newer value
  assign nzcv_d = cmp_valid ? cmp_nzcv :
                  wr_stat ? hwdata[FPCSR_NZCV_LSB +: 4] : nzcv_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= FPCSR_RST_ZERO;
      nzcv_q <= 4'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      nzcv_q <= nzcv_d;
    end
  end
  // ----------------------------------------------------------------
  // cumulative exception flags
  // ----------------------------------------------------------------
  // bits 6 and 5 carry no flag, so events there are dropped
  wire logic [7:0] exc_ev = exc_set & FPCSR_EXC_MASK[7:0];
  // writing 0 to a flag clears it, writing 1 leaves it
  wire logic [7:0] exc_clr = {8{wr_stat}} & ~hwdata[7:0] & FPCSR_EXC_MASK[7:0];
  wire logic [7:0] exc_flags;
  fpcsr_sticky #(.WIDTH(8)) u_exc (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(exc_ev),
    .clr(exc_clr),
    .flags(exc_flags)
  );
  wire logic [31:0] stat_rd = {nzcv_q, 28'h0000000} | ctrl_q | {24'h000000, exc_flags};
  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // status mirrors the exception events; read of it clears, new event wins
  logic [7:0] irqs_q, irqs_d;
  logic [7:0] irqm_q, irqm_d;
  assign irqs_d = exc_ev | (rd_irqs ? 8'h00 : irqs_q);
  // mask bits exist only where a flag exists
  assign irqm_d = wr_irqm ? (hwdata[7:0] & FPCSR_EXC_MASK[7:0]) : irqm_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irqs_q <= 8'h00;
      irqm_q <= 8'h00;
    end
    else
    begin
      irqs_q <= irqs_d;
      irqm_q <= irqm_d;
    end
  end
  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire logic [31:0] rd_mux =
    cpac_ok ? cpac_q :
    sel_ctxa ? ctxa_q :
    sel_stat ? stat_rd :
    sel_dflt ? dflt_q :
    sel_irqs ? {24'h000000, irqs_q} :
    sel_irqm ? {24'h000000, irqm_q} : FPCSR_RST_ZERO;
  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  // reads take one wait state: the first data cycle loads the word into a
  // flop, trading a cycle per read for read data that never comes from the
  // decode path; it also lets a read see a write that lands just before it
  logic [31:0] hrdata_q, hrdata_d;
  logic ready_q, ready_d;
  // a read-clear of the interrupt status falls in that first cycle, so the
  // word returned is the one from before the clear
  assign hrdata_d = rd_pend_q ? rd_mux : FPCSR_RST_ZERO;
  // ready drops for exactly one cycle after a read address is taken
  assign ready_d = !rd_pend_d;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= FPCSR_RST_ZERO;
      ready_q <= 1'b1;
    end
    else
    begin
      hrdata_q <= hrdata_d;
      ready_q <= ready_d;
    end
  end
  assign hrdata = hrdata_q;
  assign hreadyout = ready_q;
  // no transfer ends in an error; refused accesses read zero instead
  assign hresp = 1'b0;
  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic fp_enable_q, fp_allow_q, no_coprocessor_fault_q, fp_irq_q, irq_q;
  logic ahp_q, dn_q, fz_q;
  logic [1:0] rm_q;
  wire logic fp_irq_d = |(exc_flags & FPCSR_IRQ_EXC_MASK[7:0]);
  wire logic irq_d = |(irqs_d & irqm_d);
  // the unit is on only while every access field grants some access
  wire logic fp_enable_d = &cp_on_v;
  // the access outcome of an issue shows one cycle after the issue
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fp_enable_q <= 1'b0;
      fp_allow_q <= 1'b0;
      no_coprocessor_fault_q <= 1'b0;
    end
    else
    begin
      fp_enable_q <= fp_enable_d;
      fp_allow_q <= acc_allow;
      no_coprocessor_fault_q <= acc_fault;
    end
  end
  // both interrupts are levels: fp_irq follows exception flags 7 and 3..0 one cycle late, irq follows the next status and mask on the same edge as them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fp_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      fp_irq_q <= fp_irq_d;
      irq_q <= irq_d;
    end
  end
  // ----------------------------------------------------------------
  // mode outputs
  // ----------------------------------------------------------------
  // modes follow the next control value, so they change on the same edge as
  // the register and the datapath never runs an instruction on a stale mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ahp_q <= 1'b0;
      dn_q <= 1'b0;
      fz_q <= 1'b0;
      rm_q <= FPCSR_RM_NEAREST;
    end
    else
    begin
      ahp_q <= ctrl_d[FPCSR_AHP_BIT];
      dn_q <= ctrl_d[FPCSR_DN_BIT];
      fz_q <= ctrl_d[FPCSR_FZ_BIT];
      rm_q <= ctrl_d[FPCSR_RM_LSB +: 2];
    end
  end
  assign fp_enable = fp_enable_q;
  assign fp_allow = fp_allow_q;
  assign no_coprocessor_fault_fault = no_coprocessor_fault_q;
  assign fp_irq = fp_irq_q;
  assign irq = irq_q;
  assign half_precision_alt_select = ahp_q;
  assign default_nan_enable = dn_q;
  assign flush_to_zero_enable = fz_q;
  assign rounding_select = rm_q;
endmodule // fpcsr_regs

// ===== sim/fpcsr_regs_properties.sv
// port-level assertions for the fp control/status register bank
`timescale 1ns/1ps
module fpcsr_regs_properties
  import fpcsr_pkg::*;
(
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // size
  input wire logic [3:0] hprot, // prot
  input wire logic hready, // ready
  input wire logic [31:0] hrdata, // rdata
  input wire logic hreadyout, // ready out
  input wire logic hresp, // resp
  input wire logic fp_issue, // issue
  input wire logic fp_issue_priv, // priv issue
  input wire logic [7:0] exc_set, // events
  input wire logic fp_enable, // enabled
  input wire logic fp_allow, // allowed
  input wire logic no_coprocessor_fault_fault, // fault
  input wire logic fp_irq // exc irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // read data phase tracking
  // ----------------------------------------------------------------
  logic [9:0] ph_q;
  wire take = hsel && htrans == FPCSR_HTRANS_NONSEQ && hsize == FPCSR_HSIZE_WORD;
  // 8'hff is unmapped, so it never matches a register offset
  wire [7:0] ra = ph_q[9] ? ph_q[7:0] : 8'hff;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ph_q <= 10'h000;
    else if (hready)
      ph_q <= {take && !hwrite, hprot[1], haddr[7:0]};
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_bus_okay: assert property (!hresp)
    else $error("bus answer not okay");
  a_read_wait: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_ctx_low: assert property (ra == FPCSR_OFF_CTXA |-> hrdata[2:0] == 3'h0)
    else $error("context address low bits not zero");
  a_stat_resv: assert property (ra == FPCSR_OFF_STAT |->
    (hrdata & ~(FPCSR_NZCV_MASK | FPCSR_CTRL_MASK | FPCSR_EXC_MASK)) == 32'h0)
    else $error("status reserved bits not zero");
  a_dflt_resv: assert property (ra == FPCSR_OFF_DFLT |-> (hrdata & ~FPCSR_CTRL_MASK) == 32'h0)
    else $error("default register reserved bits not zero");
  a_cpac_priv: assert property (ra == FPCSR_OFF_CPAC |->
    (hrdata & ~(ph_q[8] ? FPCSR_CPAC_MASK : 32'h0)) == 32'h0)
    else $error("access control read leaks bits");
  a_reset_off: assert property ($rose(hresetn) |-> !fp_enable && !no_coprocessor_fault_fault && !fp_irq)
    else $error("unit not disabled after reset");
  a_deny_fault: assert property (fp_issue && fp_issue_priv && !fp_enable ##1 !fp_enable
    |-> no_coprocessor_fault_fault && !fp_allow)
    else $error("issue on disabled unit not faulted");
  a_issue_answer: assert property (fp_issue |=> fp_allow != no_coprocessor_fault_fault)
    else $error("issue not answered by exactly one outcome");
  a_allow_on: assert property (fp_allow |-> fp_enable)
    else $error("issue allowed while unit disabled");
  a_fault_cause: assert property (no_coprocessor_fault_fault |-> $past(fp_issue))
    else $error("fault without an issue");
  a_irq_flags: assert property (|(exc_set & 8'h8f) |-> ##2 fp_irq)
    else $error("exception did not raise fp interrupt");
  c_stat_read: cover property (ra == FPCSR_OFF_STAT);
  c_fault: cover property (no_coprocessor_fault_fault);
  c_irq: cover property (fp_irq);
  c_read_wait: cover property (!hreadyout);
endmodule // fpcsr_regs_properties

bind fpcsr_regs fpcsr_regs_properties i_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hprot, .hready, .hrdata,
  .hreadyout, .hresp, .fp_issue, .fp_issue_priv, .exc_set, .fp_enable, .fp_allow,
  .no_coprocessor_fault_fault, .fp_irq
);

// ===== sim/tb.sv
// self-checking bench for the fp control/status register bank
`timescale 1ns/1ps
module tb;
  import fpcsr_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, fp_issue = 1'b0, fp_issue_priv = 1'b0;
  logic cmp_valid = 1'b0, ctx_new = 1'b0, ctx_alloc = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [3:0] hprot = 4'h0, cmp_nzcv = 4'h0;
  logic [7:0] exc_set = 8'h00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, ctx_addr = 32'h0, hrdata, rd, v;
  logic hreadyout, hresp, fp_enable, fp_allow, no_coprocessor_fault_fault, fp_irq, irq;
  logic half_precision_alt_select, default_nan_enable, flush_to_zero_enable;
  logic [1:0] rounding_select;
  wire [4:0] ctl = {half_precision_alt_select, default_nan_enable, flush_to_zero_enable,
    rounding_select};
  int mismatches = 0, n_checks = 0;
  // single slave: its ready is the bus ready
  fpcsr_regs i_dut (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(FPCSR_HSIZE_WORD),
    .hprot, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .fp_issue,
    .fp_issue_priv, .cmp_valid, .cmp_nzcv, .exc_set, .ctx_new, .ctx_alloc, .ctx_addr,
    .fp_enable, .fp_allow, .no_coprocessor_fault_fault, .half_precision_alt_select, .default_nan_enable,
    .flush_to_zero_enable, .rounding_select, .fp_irq, .irq
  );
  initial
  begin
    forever #2.5 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // bounded wait so a stuck slave ends the run instead of hanging it
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 16)
      begin
        mismatches++;
        stop_test;
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic p);
    htrans <= FPCSR_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    hprot <= {2'b00, p, 1'b1};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic p = 1'b1);
    bus(1'b1, a, d, p);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic p = 1'b1);
    bus(1'b0, a, 32'h0, p);
    chk(rd, e);
  endtask
  task automatic evt(input logic [7:0] e, input logic c, input logic n, input logic a);
    exc_set <= e;
    cmp_valid <= c;
    ctx_new <= n;
    ctx_alloc <= a;
    tick(1);
    {exc_set, cmp_valid, ctx_new, ctx_alloc} <= 11'h000;
  endtask
  task automatic issue(input logic p, input logic ok);
    fp_issue <= 1'b1;
    fp_issue_priv <= p;
    tick(1);
    fp_issue <= 1'b0;
    tick(1);
    chk(32'({fp_allow, no_coprocessor_fault_fault}), 32'({ok, !ok}));
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    tick(16);
    hresetn <= 1'b1;
    tick(1);
    for (int i = 0; i < 6; i++)
      rdc(8'(4 * i), FPCSR_RST_ZERO);
    chk(32'(fp_enable), 32'h0);
    issue(1'b1, 1'b0);
    wr(8'h18, 32'hffff_ffff);
    rdc(8'h18, 32'h0);
    wr(FPCSR_OFF_CPAC, 32'h00f0_0000, 1'b0);
    rdc(FPCSR_OFF_CPAC, 32'h0);
    wr(FPCSR_OFF_CPAC, 32'hffff_ffff);
    rdc(FPCSR_OFF_CPAC, FPCSR_CPAC_MASK);
    rdc(FPCSR_OFF_CPAC, 32'h0, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      wr(FPCSR_OFF_CPAC, (32'(c) << FPCSR_CP10_LSB) | (32'(c) << FPCSR_CP11_LSB));
      tick(2);
      chk(32'(fp_enable), 32'(c[0]));
      issue(1'b0, c == 3);
      issue(1'b1, c[0]);
    end
    ctx_addr <= 32'h2000_1237;
    evt(8'h00, 1'b0, 1'b0, 1'b1);
    rdc(FPCSR_OFF_CTXA, 32'h2000_1230);
    wr(FPCSR_OFF_CTXA, 32'h1234_5677);
    rdc(FPCSR_OFF_CTXA, 32'h1234_5670);
    // bit 27 is reserved, so the last pass also checks it is dropped
    for (int i = 0; i < 4; i++)
    begin
      v = (32'h1 << (24 + i)) | (32'(i) << FPCSR_RM_LSB);
      wr(FPCSR_OFF_STAT, v);
      tick(2);
      chk(32'(ctl), 32'({v[26:24], 2'(i)}));
      rdc(FPCSR_OFF_STAT, v & FPCSR_CTRL_MASK);
    end
    cmp_nzcv <= 4'ha;
    evt(8'h00, 1'b1, 1'b0, 1'b0);
    rdc(FPCSR_OFF_STAT, 32'ha0c0_0000);
    wr(FPCSR_OFF_STAT, 32'h0);
    wr(FPCSR_OFF_IRQM, 32'h0000_0001);
    evt(8'h10, 1'b0, 1'b0, 1'b0);
    tick(2);
    chk(32'({fp_irq, irq}), 32'h0);
    evt(8'h8f, 1'b0, 1'b0, 1'b0);
    tick(2);
    chk(32'({fp_irq, irq}), 32'h3);
    rdc(FPCSR_OFF_IRQS, 32'h0000_009f);
    tick(2);
    chk(32'(irq), 32'h0);
    rdc(FPCSR_OFF_IRQS, 32'h0);
    rdc(FPCSR_OFF_STAT, FPCSR_EXC_MASK);
    wr(FPCSR_OFF_STAT, 32'h0000_0010);
    tick(2);
    chk(32'(fp_irq), 32'h0);
    rdc(FPCSR_OFF_STAT, 32'h0000_0010);
    wr(FPCSR_OFF_DFLT, 32'hffff_ffff);
    rdc(FPCSR_OFF_DFLT, FPCSR_CTRL_MASK);
    evt(8'h00, 1'b0, 1'b1, 1'b0);
    tick(2);
    chk(32'(ctl), 32'h1f);
    rdc(FPCSR_OFF_STAT, FPCSR_CTRL_MASK | 32'h10);
    stop_test;
  end
endmodule // tb
